// file: csss_pkg.sv
/*
 * Shared constants for the clock source and start-up select block:
 * fuse codes, start-up counts, delay times, register map and FSM states.
 * Assumes a single 50 MHz register clock and fuse levels that are stable around reset.
 */
package csss_pkg;

    // Register clock rate, used to turn delay times into cycle counts
    localparam int CLK_FREQ_MHZ = 50;

    // Clock source select fuse codes (full four bits)
    localparam logic [3:0] SRC_RC_OSC    = 4'h2;
    localparam logic [3:0] SRC_LP128_OSC = 4'h3;
    // Upper three bits for the watch crystal; bit 0 then picks the wake count
    localparam logic [2:0] SRC_LF_XTAL_DEFAULT = 3'h2;

    // Start-up time fuse codes
    localparam logic [1:0] SUT_BOD      = 2'h0;
    localparam logic [1:0] SUT_FAST     = 2'h1;
    localparam logic [1:0] SUT_SLOW     = 2'h2;
    localparam logic [1:0] SUT_RESERVED = 2'h3;

    // Shipped configuration
    localparam logic [3:0] SHIP_SOURCE = 4'h2;
    localparam logic [1:0] SHIP_SUT    = 2'h2;
    localparam logic       SHIP_DIV8   = 1'b1;

    // Start-up counts in source oscillator cycles
    localparam int WAKE_LF_SHORT = 1024;
    localparam int WAKE_LF_LONG  = 32768;
    localparam int WAKE_INTERNAL = 6;
    localparam int RESET_SRC_CK  = 14;

    // Extra reset delays in microseconds, and their counts at the register clock
    localparam int DLY_4P1_US  = 4100;
    localparam int DLY_65_US   = 65000;
    localparam int DLY_4_US    = 4000;
    localparam int DLY_64_US   = 64000;
    localparam int DLY_4P1_CYC = DLY_4P1_US * CLK_FREQ_MHZ;
    localparam int DLY_65_CYC  = DLY_65_US * CLK_FREQ_MHZ;
    localparam int DLY_4_CYC   = DLY_4_US * CLK_FREQ_MHZ;
    localparam int DLY_64_CYC  = DLY_64_US * CLK_FREQ_MHZ;

    // Prescaler select reset values
    localparam logic [3:0] PRESC_DIV1 = 4'h0;
    localparam logic [3:0] PRESC_DIV8 = 4'h3;

    // Register byte addresses
    localparam logic [7:0] ADR_TRIM   = 8'h00;
    localparam logic [7:0] ADR_PRESC  = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;

    // Trim register fields
    localparam int TRIM_RANGE_POS = 7;
    localparam int TRIM_FINE_MSB  = 6;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_GATE_POS  = 3;
    localparam int STAT_SUT_LSB   = 4;
    localparam int STAT_RPD_POS   = 6;
    localparam int STAT_FAULT_POS = 7;

    typedef enum logic [2:0] {
        ST_RESET_CK = 3'h0,
        ST_RESET_MS = 3'h1,
        ST_RUN      = 3'h2,
        ST_SLEEP    = 3'h3,
        ST_WAKE     = 3'h4,
        ST_FAULT    = 3'h5
    } csss_state_t;

endpackage

// file: csss_reg_if.sv
/*
 * Carrier between the start-up core and its register slave.
 * Assumes both ends sit in the same clock domain.
 */
interface csss_reg_if;
    logic [7:0] factoryTrim;
    logic       div8Fuse;
    logic [7:0] status;
    logic [7:0] trim;
    logic [3:0] prescaler;

    modport slave (input factoryTrim, input div8Fuse, input status, output trim, output prescaler);
    modport core  (output factoryTrim, output div8Fuse, output status, input trim, input prescaler);
endinterface

// file: csss_delay_counter.sv
/*
 * Down counter for start-up delays: loads on start, decrements on each tick,
 * pulses done when the count has elapsed.
 * Assumes start and tick are synchronous single-cycle qualifiers.
 */
module csss_delay_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             tick,
    output logic                  busy,
    output logic                  done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             busy;
        logic             done;
    } csss_cnt_t;

    csss_cnt_t cnt_reg;
    csss_cnt_t cnt_next;

    if (WIDTH < 2 || WIDTH > 31) begin : g_chk
        $error("csss_delay_counter: WIDTH out of range");
    end

    // A zero load finishes at once so callers need no special case
    always_comb begin
        cnt_next      = cnt_reg;
        cnt_next.done = 1'b0;
        if (!rst_n) begin
            cnt_next = '0;
        end else if (start) begin
            cnt_next.count = loadValue;
            cnt_next.busy  = (loadValue != '0);
            cnt_next.done  = (loadValue == '0);
        end else if (cnt_reg.busy && tick) begin
            if (cnt_reg.count <= WIDTH'(1)) begin
                cnt_next.count = '0;
                cnt_next.busy  = 1'b0;
                cnt_next.done  = 1'b1;
            end else begin
                cnt_next.count = cnt_reg.count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        cnt_reg <= cnt_next;
    end

    assign busy = cnt_reg.busy;
    assign done = cnt_reg.done;
endmodule // csss_delay_counter

// file: csss_wb_regs.sv
/*
 * Classic Wishbone register slave holding the oscillator trim and prescaler select,
 * and returning the core's status word.
 * Assumes a single-cycle classic master that holds its request until ack.
 */
module csss_wb_regs
    import csss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    csss_reg_if.slave        regs
);
    typedef struct packed {
        logic [7:0]  trim;
        logic [3:0]  prescaler;
        logic        ack;
        logic [31:0] rdata;
    } csss_wb_t;

    csss_wb_t wb_reg;
    csss_wb_t wb_next;
    logic     request;
    logic     commit;

    assign request = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master samples ack, never earlier
    assign commit  = request && wb_ack_o && wb_we_i && wb_sel_i[0];

    always_comb begin
        wb_next     = wb_reg;
        wb_next.ack = request && !wb_reg.ack;
        if (!rst_n) begin
            wb_next.trim      = regs.factoryTrim;
            wb_next.prescaler = regs.div8Fuse ? PRESC_DIV8 : PRESC_DIV1;
            wb_next.ack       = 1'b0;
            wb_next.rdata     = '0;
        end else begin
            if (request && !wb_reg.ack) begin
                // Unmapped addresses are acknowledged and read as zero
                case (wb_adr_i)
                    ADR_TRIM:   wb_next.rdata = {24'h000000, wb_reg.trim};
                    ADR_PRESC:  wb_next.rdata = {28'h0000000, wb_reg.prescaler};
                    ADR_STATUS: wb_next.rdata = {24'h000000, regs.status};
                    default:    wb_next.rdata = '0;
                endcase
            end
            if (commit && wb_adr_i == ADR_TRIM) begin
                wb_next.trim = wb_dat_i[7:0];
            end
            if (commit && wb_adr_i == ADR_PRESC) begin
                wb_next.prescaler = wb_dat_i[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        wb_reg <= wb_next;
    end

    assign wb_ack_o       = wb_reg.ack;
    assign wb_dat_o       = wb_reg.rdata;
    assign regs.trim      = wb_reg.trim;
    assign regs.prescaler = wb_reg.prescaler;
endmodule // csss_wb_regs

// file: csss_clock_select.sv
/*
 * Clock source and start-up select core. Latches the clock fuses at reset,
 * picks the system clock source, times the reset and wake start-up delays and
 * gates the system clock until they elapse. Also holds the oscillator trim and
 * prescaler select through a Wishbone register slave.
 * Assumes each source oscillator delivers a one-cycle tick per period,
 * synchronous to clk, and that fuse inputs are stable while rst_n is low.
 */
module csss_clock_select
    import csss_pkg::*;
#(
    parameter logic [2:0] LF_XTAL_CODE     = SRC_LF_XTAL_DEFAULT,
    parameter int         RESET_4P1MS_CYC  = DLY_4P1_CYC,
    parameter int         RESET_65MS_CYC   = DLY_65_CYC,
    parameter int         RESET_4MS_CYC    = DLY_4_CYC,
    parameter int         RESET_64MS_CYC   = DLY_64_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  clockSourceFuses,
    input  wire logic [1:0]  startupTimeFuses,
    input  wire logic        divideByEightFuse,
    input  wire logic        resetPinDisableFuse,
    input  wire logic        useShippedDefaults,
    input  wire logic [7:0]  factoryTrimByte,
    input  wire logic        lfXtalTick,
    input  wire logic        rcOscTick,
    input  wire logic        lpOscTick,
    input  wire logic        sleepRequest,
    output logic             sysClkEnable,
    output logic             selLfXtal,
    output logic             selRcOsc,
    output logic             selLp128Osc,
    output logic             configFault,
    output logic             trimRangeBit,
    output logic      [6:0]  trimFineField,
    output logic      [3:0]  prescalerSelectField
);
    localparam int TICK_W = 16;
    localparam int MS_W   = 22;

    // Every delay must fit its counter, or the gate would open early
    if (RESET_4P1MS_CYC < 0 || RESET_4P1MS_CYC >= (1 << MS_W) ||
        RESET_65MS_CYC  < 0 || RESET_65MS_CYC  >= (1 << MS_W) ||
        RESET_4MS_CYC   < 0 || RESET_4MS_CYC   >= (1 << MS_W) ||
        RESET_64MS_CYC  < 0 || RESET_64MS_CYC  >= (1 << MS_W)) begin : g_chk_ms
        $error("csss_clock_select: reset delay does not fit the counter");
    end
    if (WAKE_LF_LONG >= (1 << TICK_W)) begin : g_chk_tick
        $error("csss_clock_select: wake count does not fit the counter");
    end

    // Fuse image caught while in reset, plus the start-up sequencer
    typedef struct packed {
        logic [3:0]  source;
        logic [1:0]  startup_time_fuses;
        logic        rstPinDis;
        csss_state_t state;
        logic        armed;
        logic        gate;
        logic        fault;
    } csss_core_t;

    csss_core_t core_reg;
    csss_core_t core_next;

    csss_reg_if regBus ();

    logic              isLfXtal;
    logic              isRc;
    logic              isLp128;
    logic              srcTick;
    logic [TICK_W-1:0] wakeCount;
    logic [MS_W-1:0]   resetMsCount;
    logic              sutReserved;
    logic              tickStart;
    logic [TICK_W-1:0] tickLoad;
    logic              tickDone;
    logic              msStart;
    logic              msDone;

    // Source decode from the latched fuse image
    assign isLfXtal = (core_reg.source[3:1] == LF_XTAL_CODE);
    assign isRc     = (core_reg.source == SRC_RC_OSC);
    assign isLp128  = (core_reg.source == SRC_LP128_OSC);

    // Only the selected oscillator advances the start-up counts
    assign srcTick = (isLfXtal && lfXtalTick) ||
                     (isRc && rcOscTick) ||
                     (isLp128 && lpOscTick);

    // Code 11 is refused for every source, crystal included
    assign sutReserved = (core_reg.startup_time_fuses == SUT_RESERVED);

    // Wake count after power-down or power-save
    always_comb begin
        if (isLfXtal) begin
            wakeCount = core_reg.source[0] ? TICK_W'(WAKE_LF_LONG)
                                           : TICK_W'(WAKE_LF_SHORT);
        end else begin
            wakeCount = TICK_W'(WAKE_INTERNAL);
        end
    end

    // Extra reset delay in register clock cycles; the slow internal source uses its own figures for the fast and slow codes
    always_comb begin
        resetMsCount = '0;
        case (core_reg.startup_time_fuses)
            SUT_BOD: begin
                // Without the reset pin, a longer window on the RC and LP128 sources keeps programming entry possible
                if (core_reg.rstPinDis && (isRc || isLp128)) begin
                    resetMsCount = MS_W'(RESET_4P1MS_CYC);
                end
            end
            SUT_FAST: begin
                resetMsCount = isLp128 ? MS_W'(RESET_4MS_CYC)
                                       : MS_W'(RESET_4P1MS_CYC);
            end
            SUT_SLOW: begin
                resetMsCount = isLp128 ? MS_W'(RESET_64MS_CYC)
                                       : MS_W'(RESET_65MS_CYC);
            end
            default: begin
                resetMsCount = '0;
            end
        endcase
    end

    // Sequencer: reset cycles, reset time-out, run, sleep, wake
    always_comb begin
        core_next = core_reg;
        tickStart = 1'b0;
        tickLoad  = '0;
        msStart   = 1'b0;
        if (!rst_n) begin
            // Fuses are caught by this clocked path, never by the reset itself
            if (useShippedDefaults) begin
                core_next.source = SHIP_SOURCE;
                core_next.startup_time_fuses    = SHIP_SUT;
            end else begin
                core_next.source = clockSourceFuses;
                core_next.startup_time_fuses    = startupTimeFuses;
            end
            core_next.rstPinDis = resetPinDisableFuse;
            core_next.state     = ST_RESET_CK;
            core_next.armed     = 1'b0;
            core_next.gate      = 1'b0;
            core_next.fault     = 1'b0;
        end else begin
            case (core_reg.state)
                ST_RESET_CK: begin
                    if (!(isLfXtal || isRc || isLp128) || sutReserved) begin
                        core_next.state = ST_FAULT;
                        core_next.fault = 1'b1;
                    end else if (!core_reg.armed) begin
                        tickStart       = 1'b1;
                        tickLoad        = TICK_W'(RESET_SRC_CK);
                        core_next.armed = 1'b1;
                    end else if (tickDone) begin
                        msStart         = 1'b1;
                        core_next.state = ST_RESET_MS;
                    end
                end
                ST_RESET_MS: begin
                    // Time-out counts the register clock whatever source is chosen
                    if (msDone) begin
                        core_next.state = ST_RUN;
                        core_next.gate  = 1'b1;
                        core_next.armed = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (sleepRequest) begin
                        core_next.state = ST_SLEEP;
                        core_next.gate  = 1'b0;
                    end
                end
                ST_SLEEP: begin
                    if (!sleepRequest) begin
                        tickStart       = 1'b1;
                        tickLoad        = wakeCount;
                        core_next.state = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (tickDone) begin
                        core_next.state = ST_RUN;
                        core_next.gate  = 1'b1;
                    end
                end
                ST_FAULT: begin
                    // Clock stays gated until the fuses are fixed and reset applied
                    core_next.gate = 1'b0;
                end
                default: begin
                    core_next.state = ST_FAULT;
                    core_next.fault = 1'b1;
                    core_next.gate  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        core_reg <= core_next;
    end

    // Source cycle counter for reset cycles and wake
    csss_delay_counter #(
        .WIDTH     (TICK_W)
    ) u_tick_cnt (
        .clk       (clk),
        .rst_n     (rst_n),
        .start     (tickStart),
        .loadValue (tickLoad),
        .tick      (srcTick),
        .busy      (),
        .done      (tickDone)
    );

    // Register clock counter for the reset time-out
    csss_delay_counter #(
        .WIDTH     (MS_W)
    ) u_ms_cnt (
        .clk       (clk),
        .rst_n     (rst_n),
        .start     (msStart),
        .loadValue (resetMsCount),
        .tick      (1'b1),
        .busy      (),
        .done      (msDone)
    );

    // Register slave hookup
    assign regBus.factoryTrim = factoryTrimByte;
    assign regBus.div8Fuse    = useShippedDefaults ? SHIP_DIV8 : divideByEightFuse;
    always_comb begin
        regBus.status                                   = '0;
        regBus.status[STAT_STATE_LSB +: 3]              = core_reg.state;
        regBus.status[STAT_GATE_POS]                    = core_reg.gate;
        regBus.status[STAT_SUT_LSB +: 2]                = core_reg.startup_time_fuses;
        regBus.status[STAT_RPD_POS]                     = core_reg.rstPinDis;
        regBus.status[STAT_FAULT_POS]                   = core_reg.fault;
    end

    csss_wb_regs u_regs (
        .clk      (clk),
        .rst_n    (rst_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .regs     (regBus)
    );

    // Oscillator controls; overlap of the two ranges is the analog side's business
    assign trimRangeBit         = regBus.trim[TRIM_RANGE_POS];
    assign trimFineField        = regBus.trim[TRIM_FINE_MSB:0];
    assign prescalerSelectField = regBus.prescaler;

    // Outputs from state flip-flops; source selects decoded from the latched fuse image
    assign sysClkEnable = core_reg.gate;
    assign selLfXtal    = isLfXtal && !core_reg.fault;
    assign selRcOsc     = isRc && !core_reg.fault;
    assign selLp128Osc  = isLp128 && !core_reg.fault;
    assign configFault  = core_reg.fault;
endmodule // csss_clock_select

// file: csss_clock_select_sva.sv
/* Checker for csss_clock_select: bus handshake, reset loads and clock gating.
   Assumes it is bound to that module and sees only its ports. */
module csss_clock_select_sva
    import csss_pkg::*;
(
    input wire logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [7:0]  wb_adr_i, factoryTrimByte,
    input wire logic [3:0]  wb_sel_i, prescalerSelectField,
    input wire logic [31:0] wb_dat_i,
    input wire logic        divideByEightFuse, useShippedDefaults, sleepRequest, sysClkEnable, configFault,
    input wire logic        lfXtalTick, rcOscTick, lpOscTick, selLfXtal, selRcOsc, selLp128Osc, trimRangeBit,
    input wire logic [6:0]  trimFineField
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tickCnt_reg;
    // Selected-source ticks while gated; a short count would ungate too early
    always_ff @(posedge clk) begin
        if (!rst_n || sysClkEnable) tickCnt_reg <= 16'h0;
        else if ((selRcOsc && rcOscTick) || (selLfXtal && lfXtalTick) || (selLp128Osc && lpOscTick))
            tickCnt_reg <= tickCnt_reg + 16'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Steps of a bus access and of leaving reset
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_trim_wr; wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == ADR_TRIM; endsequence
    sequence s_leave_rst; $rose(rst_n); endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_trim_write: assert property (s_trim_wr |=> {trimRangeBit, trimFineField} == 8'($past(wb_dat_i)))
        else $error("trim write not taken");
    a_trim_reload: assert property (s_leave_rst |-> {trimRangeBit, trimFineField} == $past(factoryTrimByte))
        else $error("factory trim not loaded in reset");
    a_presc_reset: assert property (s_leave_rst |-> prescalerSelectField ==
        (($past(divideByEightFuse) || $past(useShippedDefaults)) ? PRESC_DIV8 : PRESC_DIV1))
        else $error("prescaler reset value wrong");
    a_gate_startup: assert property (s_leave_rst |-> !sysClkEnable [*8])
        else $error("clock ungated too soon after reset");
    a_sleep_gate: assert property (sysClkEnable && sleepRequest |=> !sysClkEnable)
        else $error("clock not gated on sleep");
    a_wake_count: assert property ($rose(sysClkEnable) |-> tickCnt_reg >= 16'h6)
        else $error("ungated before six source ticks");
    a_fault_gate: assert property (configFault |-> !sysClkEnable && !selLfXtal && !selRcOsc && !selLp128Osc)
        else $error("clock or source active in fault");
    a_one_source: assert property ($onehot0({selLfXtal, selRcOsc, selLp128Osc}))
        else $error("more than one source selected");
endmodule // csss_clock_select_sva

bind csss_clock_select csss_clock_select_sva u_sva (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .wb_adr_i, .factoryTrimByte, .wb_sel_i, .prescalerSelectField, .wb_dat_i, .divideByEightFuse,
    .useShippedDefaults, .sleepRequest, .sysClkEnable, .configFault, .lfXtalTick, .rcOscTick, .lpOscTick,
    .selLfXtal, .selRcOsc, .selLp128Osc, .trimRangeBit, .trimFineField);

// file: csss_osc_model.sv
/* Model of the three source oscillators: a one-cycle tick per period each.
   Assumes periods counted in register clock cycles; sources run free. */
module csss_osc_model #(
    parameter int LF_DIV = 2,
    parameter int RC_DIV = 2,
    parameter int LP_DIV = 3
) (
    input  wire logic clk,
    output logic      lfXtalTick,
    output logic      rcOscTick,
    output logic      lpOscTick
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_reg = 0;
    // Oscillators never stop, so gating must come from the block itself
    always_ff @(posedge clk) cnt_reg <= cnt_reg + 1;
    // Different phases keep the crystal and RC ticks apart; every LP tick lands on one of them
    assign lfXtalTick = (cnt_reg % LF_DIV) == 0;
    assign rcOscTick  = (cnt_reg % RC_DIV) == 1;
    assign lpOscTick  = (cnt_reg % LP_DIV) == 2;
endmodule // csss_osc_model

// file: tb.sv
/* Self-checking bench for csss_clock_select with shortened reset delays.
   Assumes the oscillator model and the bound checker are compiled alongside. */
module tb
    import csss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [3:0] cs; logic [1:0] startup_time_fuses; logic [2:0] fl; logic [2:0] sl; logic flt;
        logic [7:0] lo; } csss_row_t;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
    logic        div8 = 1'b0, rpd = 1'b0, ship = 1'b0, ack, lfT, rcT, lpT, en, sLf, sRc, sLp, fault, tRange;
    logic [7:0]  adr = 8'h00, fTrim = 8'h00;
    logic [3:0]  sel = 4'h0, csf = 4'h0, presc;
    logic [1:0]  startup_time_fuses = 2'h0;
    logic [6:0]  tFine;
    logic [31:0] dat = 32'h0, rdat, q;
    int          failCount = 0, comparisons = 0, n;
    // Fields: source, start-up code, {div8, pin-disable, shipped}, {lf, rc, lp}, fault, earliest ungate
    csss_row_t rows[15] = '{'{4'h2, 2'h0, 3'h0, 3'h2, 1'h0, 8'h1C}, '{4'h2, 2'h1, 3'h4, 3'h2, 1'h0, 8'h30},
        '{4'h2, 2'h2, 3'h0, 3'h2, 1'h0, 8'h49}, '{4'h2, 2'h0, 3'h2, 3'h2, 1'h0, 8'h30},
        '{4'h2, 2'h3, 3'h0, 3'h0, 1'h1, 8'h00}, '{4'h3, 2'h0, 3'h0, 3'h1, 1'h0, 8'h2A},
        '{4'h3, 2'h1, 3'h0, 3'h1, 1'h0, 8'h4D}, '{4'h3, 2'h2, 3'h4, 3'h1, 1'h0, 8'h61},
        '{4'h3, 2'h0, 3'h2, 3'h1, 1'h0, 8'h3E}, '{4'h4, 2'h0, 3'h0, 3'h4, 1'h0, 8'h1C},
        '{4'h5, 2'h1, 3'h0, 3'h4, 1'h0, 8'h30}, '{4'h4, 2'h2, 3'h4, 3'h4, 1'h0, 8'h49},
        '{4'h5, 2'h3, 3'h0, 3'h0, 1'h1, 8'h00}, '{4'hF, 2'h0, 3'h1, 3'h2, 1'h0, 8'h49},
        '{4'hF, 2'h0, 3'h0, 3'h0, 1'h1, 8'h00}};
    logic [3:0] wSrc[3] = '{4'h2, 4'h3, 4'h4};
    int wLo[3] = '{12, 18, 2048}, sLo[3] = '{28, 42, 28}, wP[3] = '{2, 3, 2};

    always #10 clk = ~clk;
    // Delays shortened so each start-up fits in a few hundred cycles
    csss_clock_select #(.RESET_4P1MS_CYC(20), .RESET_65MS_CYC(45), .RESET_4MS_CYC(35), .RESET_64MS_CYC(55)) DUT (
        .clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .clockSourceFuses(csf), .startupTimeFuses(startup_time_fuses),
        .divideByEightFuse(div8), .resetPinDisableFuse(rpd), .useShippedDefaults(ship), .factoryTrimByte(fTrim),
        .lfXtalTick(lfT), .rcOscTick(rcT), .lpOscTick(lpT), .sleepRequest(sleep), .sysClkEnable(en),
        .selLfXtal(sLf), .selRcOsc(sRc), .selLp128Osc(sLp), .configFault(fault), .trimRangeBit(tRange),
        .trimFineField(tFine), .prescalerSelectField(presc));
    csss_osc_model MODEL (.clk, .lfXtalTick(lfT), .rcOscTick(rcT), .lpOscTick(lpT));

    // Comparison, verdict and bus helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic endSim();
        $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Request held until ack is sampled; read data taken at that edge only
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (k >= 20) begin failCount++; endSim(); end
    endtask
    task automatic doReset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Edges until the clock is ungated must fall in a window; tick phase makes it a range
    task automatic waitEn(input int lo, input int hi);
        n = 0;
        while (en !== 1'b1 && n <= hi) begin @(posedge clk); n++; end
        chk(32'(n >= lo && n <= hi), 32'h1);
        if (n > hi) endSim();
    endtask

    initial begin
        foreach (rows[i]) begin
            {csf, startup_time_fuses, div8, rpd, ship, fTrim} <= {rows[i].cs, rows[i].startup_time_fuses, rows[i].fl, 8'h78 + 8'(i)};
            doReset();
            @(posedge clk);
            chk({tRange, tFine}, fTrim);
            chk(presc, (div8 | ship) ? PRESC_DIV8 : PRESC_DIV1);
            if (rows[i].flt) begin
                repeat (200) @(posedge clk);
                chk(en, 32'h0);
            end
            else waitEn(rows[i].lo, rows[i].lo + (rows[i].sl[0] ? 13 : 12));
            // Fault only latches on the first edge out of reset, so look once settled
            chk({sLf, sRc, sLp, fault}, {rows[i].sl, rows[i].flt});
        end
        // Register access, refused writes and an unmapped place
        {csf, startup_time_fuses, div8, rpd, ship, fTrim} <= {4'h2, 2'h0, 3'h0, 8'h80};
        doReset();
        waitEn(28, 40);
        wb(1'b1, ADR_TRIM, 32'h7F, 4'h1);
        repeat (2) @(posedge clk);
        chk({tRange, tFine}, 32'h7F);
        wb(1'b1, ADR_TRIM, 32'h11, 4'hE);
        wb(1'b0, ADR_TRIM, 32'h0, 4'h1);
        chk(q, 32'h7F);
        wb(1'b1, ADR_PRESC, 32'h5, 4'h1);
        wb(1'b0, ADR_PRESC, 32'h0, 4'h1);
        chk(q, 32'h5);
        chk(presc, 32'h5);
        wb(1'b1, 8'h0C, 32'hFF, 4'h1);
        wb(1'b0, 8'h0C, 32'h0, 4'h1);
        chk(q, 32'h0);
        wb(1'b0, ADR_STATUS, 32'h0, 4'h1);
        chk(q & 32'h87, 32'(ST_RUN));
        // A second reset must bring back the factory byte
        doReset();
        @(posedge clk);
        chk({tRange, tFine}, 32'h80);
        // Sleep gates at once; wake waits the source's wake count
        foreach (wSrc[j]) begin
            csf <= wSrc[j];
            doReset();
            waitEn(sLo[j], sLo[j] + wP[j] + 10);
            @(posedge clk);
            sleep <= 1'b1;
            repeat (2) @(posedge clk);
            chk(en, 32'h0);
            sleep <= 1'b0;
            waitEn(wLo[j], wLo[j] + wP[j] + 10);
        end
        endSim();
    end
endmodule // tb
